// ===== dma_cpu_model.sv
// far-side model: dma event flags and cpu priority pick
`timescale 1ns/1ps
module dma_cpu_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // routed events
  input wire logic [63:0] dma_sync,
  input wire logic [15:0] cpu_int,
  // flag clear and status
  input wire logic clear,
  output logic [63:0] flags,
  output logic [4:0] top
);
  logic [63:0] flags_reg;
  logic [63:0] flags_next;
  always_comb begin
    // clear wins so a stale event cannot survive it
    flags_next = clear ? '0 : (flags_reg | dma_sync);
    top = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (cpu_int[i]) begin
        top = 5'(i);
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end
  assign flags = flags_reg;
endmodule

// ===== event_routing.sv
// event and interrupt routing: fixed dma event map and selectable cpu lines
// Functional notes
// - dma channel 0 takes host-port or pci to cpu event; pci absent leaves host port
// - sdram refresh events of interfaces a and b drive channels 3 and 20
// - pin events four to seven drive channels 4 to 7 in order
// - viterbi rx/tx, turbo rx/tx drive channels 28..31; reserved without coprocessors
// - cell rx drives channel 32, cell tx channel 40; reserved without that port
// - channel 21 reserved; 16, 22-27, 33-39, 41-47, 56-63 have no source
// - each channel also accepts transfer-completion or alternate-completion events
// - events of absent pci and cell peripherals never assert their channels; completion events still can
// - sixteen prioritized interrupt lines go to the cpu
// - line 0 is reset and highest; priority falls as number rises
// - lines 0 to 3 fixed and non-maskable, not affected by selectors
// - lines 4 to 15 maskable and carry default sources after reset
// - software writes a five-bit code per line to pick its source
// - select high register at 0x019c0000, select low at 0x019c0004
// - five-bit fields, line 4 at low bits 4:0 resetting to 00100
// - channels tied to one event, captured even when channel disabled
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module event_routing
#(
  parameter bit HasPci = 1'b1,
  parameter bit HasCell = 1'b1,
  parameter bit HasCoproc = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic [event_routing_pkg::AddrWidth-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [event_routing_pkg::DataWidth-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [event_routing_pkg::AddrWidth-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [event_routing_pkg::DataWidth-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // peripheral event levels, same clock
  input wire logic host_event,
  input wire logic pci_event,
  input wire logic timer_zero_event,
  input wire logic timer_one_event,
  input wire logic timer_two_event,
  input wire logic sdram_refresh_event_a,
  input wire logic sdram_refresh_event_b,
  input wire logic [15:0] pin_event,
  input wire logic [2:0] serial_tx_event,
  input wire logic [2:0] serial_rx_event,
  input wire logic viterbi_rx_event,
  input wire logic viterbi_tx_event,
  input wire logic turbo_rx_event,
  input wire logic turbo_tx_event,
  input wire logic cell_rx_event,
  input wire logic cell_tx_event,
  input wire logic [event_routing_pkg::DmaChannels-1:0] completion_event,
  input wire logic [event_routing_pkg::DmaChannels-1:0] alt_completion_event,
  // other interrupt sources
  input wire logic reset_event,
  input wire logic nmi_event,
  input wire logic dma_done_event,
  input wire logic emu_dma_event,
  input wire logic emu_rx_event,
  input wire logic emu_tx_event,
  input wire logic cell_int_event,
  input wire logic viterbi_int_event,
  input wire logic turbo_int_event,
  // outputs to dma and cpu
  output logic [event_routing_pkg::DmaChannels-1:0] dma_sync,
  output logic [event_routing_pkg::CpuLines-1:0] cpu_int
);
  import event_routing_pkg::*;

  // register state
  sel_t selReg [FixedLines:CpuLines-1];
  sel_t selNext [FixedLines:CpuLines-1];
  logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
  logic [AddrWidth-1:0] awAddr_reg, awAddr_next;
  logic [DataWidth-1:0] wData_reg, wData_next;
  logic [3:0] wStrb_reg, wStrb_next;
  logic bValid_reg, bValid_next;
  logic [1:0] bResp_reg, bResp_next;
  logic rValid_reg, rValid_next;
  logic [1:0] rResp_reg, rResp_next;
  logic [DataWidth-1:0] rData_reg, rData_next;
  logic [DmaChannels-1:0] dmaNext;
  logic [CpuLines-1:0] intNext;
  logic [CpuLines-1:FixedLines] selected;
  source_t sources;

  select_if selBus ();

  // pack the two selector registers from their fields
  function automatic logic [DataWidth-1:0] packReg(input bit high);
    logic [DataWidth-1:0] v;
    v = '0;
    for (int i = 0; i < 6; i++) begin
      v[FieldPos[i] +: SelWidth] = high ? selReg[FixedLines+6+i] : selReg[FixedLines+i];
    end
    return v;
  endfunction

  // byte-lane aware merge of a field
  function automatic sel_t mergeField(input sel_t old, input int pos,
      input logic [DataWidth-1:0] d, input logic [3:0] strb);
    sel_t r;
    r = old;
    for (int b = 0; b < SelWidth; b++) begin
      if (strb[(pos+b)/8]) begin
        r[b] = d[pos+b];
      end
    end
    return r;
  endfunction

  always_comb begin
    awHeld_next = awHeld_reg;
    wHeld_next = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next = wData_reg;
    wStrb_next = wStrb_reg;
    bValid_next = bValid_reg;
    bResp_next = bResp_reg;
    for (int l = FixedLines; l < CpuLines; l++) begin
      selNext[l] = selReg[l];
    end
    // address and data may arrive in either order
    if (s_axi_awvalid && !awHeld_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_reg) begin
      wHeld_next = 1'b1;
      wData_next = s_axi_wdata;
      wStrb_next = s_axi_wstrb;
    end
    if (awHeld_reg && wHeld_reg && !bValid_reg) begin
      awHeld_next = 1'b0;
      wHeld_next = 1'b0;
      bValid_next = 1'b1;
      bResp_next = RespOkay;
      if (awAddr_reg[31:2] == SelectLowAddr[31:2]) begin
        for (int i = 0; i < 6; i++) begin
          selNext[FixedLines+i] = mergeField(selReg[FixedLines+i], FieldPos[i],
            wData_reg, wStrb_reg);
        end
      end else if (awAddr_reg[31:2] == SelectHighAddr[31:2]) begin
        for (int i = 0; i < 6; i++) begin
          selNext[FixedLines+6+i] = mergeField(selReg[FixedLines+6+i], FieldPos[i],
            wData_reg, wStrb_reg);
        end
      end else begin
        bResp_next = RespSlvErr;
      end
    end
    if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
  end

  always_comb begin
    rValid_next = rValid_reg;
    rResp_next = rResp_reg;
    rData_next = rData_reg;
    if (s_axi_arvalid && !rValid_reg) begin
      rValid_next = 1'b1;
      rResp_next = RespOkay;
      rData_next = '0;
      if (s_axi_araddr[31:2] == SelectLowAddr[31:2]) begin
        rData_next = packReg(1'b0);
      end else if (s_axi_araddr[31:2] == SelectHighAddr[31:2]) begin
        rData_next = packReg(1'b1);
      end else begin
        rResp_next = RespSlvErr;
      end
    end else if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
  end

  // fixed one-event-per-channel map; unlisted channels carry only completion events
  always_comb begin
    dmaNext = '0;
    dmaNext[0] = host_event | (HasPci & pci_event);
    dmaNext[1] = timer_zero_event;
    dmaNext[2] = timer_one_event;
    dmaNext[3] = sdram_refresh_event_a;
    dmaNext[7:4] = pin_event[7:4];
    dmaNext[11:8] = pin_event[3:0];
    dmaNext[12] = serial_tx_event[0];
    dmaNext[13] = serial_rx_event[0];
    dmaNext[14] = serial_tx_event[1];
    dmaNext[15] = serial_rx_event[1];
    dmaNext[17] = serial_tx_event[2];
    dmaNext[18] = serial_rx_event[2];
    dmaNext[19] = timer_two_event;
    dmaNext[20] = sdram_refresh_event_b;
    dmaNext[28] = HasCoproc & viterbi_rx_event;
    dmaNext[29] = HasCoproc & viterbi_tx_event;
    dmaNext[30] = HasCoproc & turbo_rx_event;
    dmaNext[31] = HasCoproc & turbo_tx_event;
    dmaNext[32] = HasCell & cell_rx_event;
    dmaNext[40] = HasCell & cell_tx_event;
    dmaNext[55:48] = pin_event[15:8];
    // completion chaining on every channel; no enable gating here, the dma latches it
    dmaNext = dmaNext | completion_event | alt_completion_event;
  end

  // selectable source table, indexed by the five-bit code
  always_comb begin
    sources = '0;
    sources[0] = host_event | (HasPci & pci_event);
    sources[1] = timer_zero_event;
    sources[2] = timer_one_event;
    sources[3] = sdram_refresh_event_a;
    sources[7:4] = pin_event[7:4];
    sources[8] = dma_done_event;
    sources[9] = emu_dma_event;
    sources[10] = emu_rx_event;
    sources[11] = emu_tx_event;
    sources[12] = serial_tx_event[0];
    sources[13] = serial_rx_event[0];
    sources[14] = serial_tx_event[1];
    sources[15] = serial_rx_event[1];
    sources[16] = pin_event[0];
    sources[17] = serial_tx_event[2];
    sources[18] = serial_rx_event[2];
    sources[19] = timer_two_event;
    sources[20] = sdram_refresh_event_b;
    sources[23] = HasCell & cell_int_event;
    sources[30] = HasCoproc & viterbi_int_event;
    sources[31] = HasCoproc & turbo_int_event;
  end

  always_comb begin
    for (int l = FixedLines; l < CpuLines; l++) begin
      selBus.sel[l] = selReg[l];
    end
  end

  interrupt_mux uMux (
    .selPort(selBus.mux),
    .sources(sources),
    .selected(selected)
  );

  // index order is priority order for the cpu, 0 highest
  always_comb begin
    intNext = '0;
    intNext[0] = reset_event;
    intNext[1] = nmi_event;
    intNext[CpuLines-1:FixedLines] = selected;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int l = FixedLines; l < CpuLines; l++) begin
        selReg[l] <= ResetSel[l];
      end
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      bValid_reg <= 1'b0;
      bResp_reg <= RespOkay;
      rValid_reg <= 1'b0;
      rResp_reg <= RespOkay;
      rData_reg <= '0;
      dma_sync <= '0;
      cpu_int <= '0;
    end else begin
      for (int l = FixedLines; l < CpuLines; l++) begin
        selReg[l] <= selNext[l];
      end
      awHeld_reg <= awHeld_next;
      wHeld_reg <= wHeld_next;
      awAddr_reg <= awAddr_next;
      wData_reg <= wData_next;
      wStrb_reg <= wStrb_next;
      bValid_reg <= bValid_next;
      bResp_reg <= bResp_next;
      rValid_reg <= rValid_next;
      rResp_reg <= rResp_next;
      rData_reg <= rData_next;
      dma_sync <= dmaNext;
      cpu_int <= intNext;
    end
  end

  // ready flags registered so outputs come from flops
  logic awReady_reg, wReady_reg, arReady_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awReady_reg <= 1'b0;
      wReady_reg <= 1'b0;
      arReady_reg <= 1'b0;
    end else begin
      awReady_reg <= !awHeld_next && !(s_axi_awvalid && !awHeld_reg);
      wReady_reg <= !wHeld_next && !(s_axi_wvalid && !wHeld_reg);
      arReady_reg <= !rValid_next;
    end
  end

  assign s_axi_awready = awReady_reg;
  assign s_axi_wready = wReady_reg;
  assign s_axi_arready = arReady_reg;
  assign s_axi_bvalid = bValid_reg;
  assign s_axi_bresp = bResp_reg;
  assign s_axi_rvalid = rValid_reg;
  assign s_axi_rresp = rResp_reg;
  assign s_axi_rdata = rData_reg;
endmodule

// ===== event_routing_chk.sv
// checker for the fixed event routes
`timescale 1ns/1ps
module event_routing_chk (
  // clock and reset
  input wire logic clk, rst_n,
  // events
  input wire logic host_event, pci_event, timer_zero_event, timer_one_event,
  timer_two_event, sdram_refresh_event_a, sdram_refresh_event_b, viterbi_rx_event,
  viterbi_tx_event, turbo_rx_event, turbo_tx_event, cell_rx_event, cell_tx_event,
  reset_event, nmi_event,
  input wire logic [15:0] pin_event,
  input wire logic [2:0] serial_tx_event, serial_rx_event,
  input wire logic [63:0] completion_event, alt_completion_event,
  // outputs
  input wire logic [63:0] dma_sync,
  input wire logic [15:0] cpu_int
);
  logic [63:0] ext;
  // completion events reach every channel
  assign ext = completion_event | alt_completion_event;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_chan_zero: assert property (
    dma_sync[0] == $past(host_event | pci_event | ext[0])) else $error("chan 0 wrong");
  a_chan_sdram: assert property (
    dma_sync[3] == $past(sdram_refresh_event_a | ext[3])
    && dma_sync[20] == $past(sdram_refresh_event_b | ext[20])) else $error("sdram wrong");
  a_chan_pins: assert property (
    dma_sync[7:4] == $past(pin_event[7:4] | ext[7:4])) else $error("pins 4-7 wrong");
  a_chan_coproc: assert property (
    dma_sync[31:28] == $past({turbo_tx_event, turbo_rx_event, viterbi_tx_event,
    viterbi_rx_event} | ext[31:28])) else $error("coproc wrong");
  a_chan_cell: assert property (
    {dma_sync[40], dma_sync[32]} == $past({cell_tx_event, cell_rx_event} |
    {ext[40], ext[32]})) else $error("cell wrong");
  a_chan_none: assert property (
    {dma_sync[63:56], dma_sync[47:41], dma_sync[39:33], dma_sync[27:21], dma_sync[16]}
    == $past({ext[63:56], ext[47:41], ext[39:33], ext[27:21], ext[16]}))
    else $error("empty chan wrong");
  a_chan_timers: assert property (
    dma_sync[2:1] == $past({timer_one_event, timer_zero_event} | ext[2:1])
    && dma_sync[19] == $past(timer_two_event | ext[19])) else $error("timers wrong");
  a_chan_serial: assert property (
    {dma_sync[18:17], dma_sync[15:12]} == $past({serial_rx_event[2], serial_tx_event[2],
    serial_rx_event[1], serial_tx_event[1], serial_rx_event[0], serial_tx_event[0]}
    | {ext[18:17], ext[15:12]})) else $error("serial wrong");
  a_chan_gpio: assert property (
    {dma_sync[55:48], dma_sync[11:8]} == $past({pin_event[15:8], pin_event[3:0]} |
    {ext[55:48], ext[11:8]})) else $error("gpio wrong");
  a_line_fixed: assert property (
    cpu_int[3:0] == $past({2'b00, nmi_event, reset_event})) else $error("fixed line wrong");
endmodule
bind event_routing event_routing_chk chk (.*);

// ===== event_routing_pkg.sv
// constants and types for the event and interrupt routing block
package event_routing_pkg;
  localparam int DataWidth = 32;
  localparam int AddrWidth = 32;
  localparam int DmaChannels = 64;
  localparam int CpuLines = 16;
  localparam int FixedLines = 4;
  localparam int SelWidth = 5;
  localparam int SourceCount = 32;
  localparam logic [31:0] SelectHighAddr = 32'h019c0000;
  localparam logic [31:0] SelectLowAddr = 32'h019c0004;
  // default selector codes, lines 4..15
  localparam logic [4:0] ResetSel [FixedLines:CpuLines-1] = '{
    5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
    5'h03, 5'h0a, 5'h0b, 5'h00, 5'h01, 5'h02};
  // bit position of each selector field within its register
  localparam int FieldPos [0:5] = '{0, 5, 10, 16, 21, 26};
  localparam logic [1:0] RespOkay = 2'b00;
  localparam logic [1:0] RespSlvErr = 2'b10;
  typedef logic [SelWidth-1:0] sel_t;
  typedef logic [SourceCount-1:0] source_t;
endpackage

// ===== event_routing_tb.sv
// self-checking bench for the event and interrupt routing block
`timescale 1ns/1ps
module event_routing_tb;
  import event_routing_pkg::*;
  logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic host_event, pci_event, timer_zero_event, timer_one_event, timer_two_event;
  logic sdram_refresh_event_a, sdram_refresh_event_b, viterbi_rx_event, viterbi_tx_event;
  logic turbo_rx_event, turbo_tx_event, cell_rx_event, cell_tx_event, reset_event;
  logic nmi_event, dma_done_event, emu_dma_event, emu_rx_event, emu_tx_event;
  logic cell_int_event, viterbi_int_event, turbo_int_event, clear;
  logic [15:0] pin_event, cpu_int;
  logic [2:0] serial_tx_event, serial_rx_event;
  logic [63:0] completion_event, alt_completion_event, dma_sync, flags;
  logic [4:0] top;
  int fails, compares, cycles;
  event_routing uut (.*);
  dma_cpu_model model (.*);
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, exp);
    cmp(64'(got), 64'(exp));
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic axi_write(input logic [31:0] a, d, output logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task automatic set_code(input int c, input logic v);
    case (c)
      0: host_event <= v;
      1: timer_zero_event <= v;
      2: timer_one_event <= v;
      3: sdram_refresh_event_a <= v;
      4, 5, 6, 7: pin_event[c] <= v;
      8: dma_done_event <= v;
      9: emu_dma_event <= v;
      10: emu_rx_event <= v;
      11: emu_tx_event <= v;
      12, 14: serial_tx_event[(c - 12) / 2] <= v;
      13, 15: serial_rx_event[(c - 13) / 2] <= v;
      16: pin_event[0] <= v;
      17: serial_tx_event[2] <= v;
      18: serial_rx_event[2] <= v;
      19: timer_two_event <= v;
      20: sdram_refresh_event_b <= v;
      23: cell_int_event <= v;
      30: viterbi_int_event <= v;
      31: turbo_int_event <= v;
      default: ;
    endcase
  endtask
  task automatic set_periph(input logic v);
    {host_event, pci_event, timer_zero_event, timer_one_event, timer_two_event,
     sdram_refresh_event_a, sdram_refresh_event_b, viterbi_rx_event, viterbi_tx_event,
     turbo_rx_event, turbo_tx_event, cell_rx_event, cell_tx_event, pin_event,
     serial_tx_event, serial_rx_event} <= {35{v}};
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(32'h019c0004, d, r);
    cmp(d, 32'h250718a4);
    cmp_resp(r, RespOkay);
    axi_read(32'h019c0000, d, r);
    cmp(d, 32'h08202d43);
    axi_write(32'h019c0008, 32'h0, r);
    cmp_resp(r, RespSlvErr);
    axi_read(32'h019c0008, d, r);
    cmp_resp(r, RespSlvErr);
  endtask
  task automatic t_defaults();
    int codes [12] = '{4, 5, 6, 7, 8, 9, 3, 10, 11, 0, 1, 2};
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      set_code(codes[i], 1);
      settle();
      cmp(cpu_int, 16'h1 << (i + 4));
      @(posedge clk);
      set_code(codes[i], 0);
    end
  endtask
  task automatic t_codes();
    logic [31:0] d;
    logic [1:0] r;
    logic has;
    // every code goes through line 4 and line 10 at once
    for (int c = 0; c < 32; c++) begin
      axi_write(32'h019c0004, 32'h250718a0 | c, r);
      axi_write(32'h019c0000, 32'h08202d40 | c, r);
      @(posedge clk);
      set_code(c, 1);
      settle();
      has = !(c == 21 || c == 22 || (c >= 24 && c <= 29));
      cmp({cpu_int[10], cpu_int[4], cpu_int[3:0]}, {has, has, 4'h0});
      @(posedge clk);
      set_code(c, 0);
    end
    axi_write(32'h019c0000, 32'h08202d43, r);
    cmp_resp(r, RespOkay);
    axi_read(32'h019c0000, d, r);
    cmp(d, 32'h08202d43);
    // line 4 back to its default so later scenarios see the reset routing
    axi_write(32'h019c0004, 32'h250718a4, r);
    axi_read(32'h019c0004, d, r);
    cmp(d, 32'h250718a4);
  endtask
  task automatic t_dma();
    @(posedge clk);
    set_periph(1);
    settle();
    cmp(dma_sync, 64'h00ff0101_f01effff);
    @(posedge clk);
    set_periph(0);
    @(posedge clk);
    pci_event <= 1;
    settle();
    cmp(dma_sync, 64'h1);
    @(posedge clk);
    pci_event <= 0;
    for (int k = 0; k < 64; k++) begin
      @(posedge clk);
      completion_event <= k[0] ? 64'h0 : 64'h1 << k;
      alt_completion_event <= k[0] ? 64'h1 << k : 64'h0;
      settle();
      cmp(dma_sync, 64'h1 << k);
    end
    @(posedge clk);
    completion_event <= 0;
    alt_completion_event <= 0;
    clear <= 1;
    repeat (2) @(posedge clk);
    clear <= 0;
    timer_zero_event <= 1;
    @(posedge clk);
    timer_zero_event <= 0;
    settle();
    cmp(flags, 64'h2);
  endtask
  task automatic t_prio();
    @(posedge clk);
    reset_event <= 1;
    nmi_event <= 1;
    pin_event[4] <= 1;
    timer_one_event <= 1;
    settle();
    cmp(top, 5'h0);
    @(posedge clk);
    reset_event <= 0;
    settle();
    cmp(top, 5'h1);
    @(posedge clk);
    nmi_event <= 0;
    settle();
    cmp(top, 5'h4);
    @(posedge clk);
    pin_event[4] <= 0;
    settle();
    cmp(top, 5'hf);
  endtask
  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     s_axi_awaddr, s_axi_wdata, s_axi_araddr, reset_event, nmi_event, dma_done_event,
     emu_dma_event, emu_rx_event, emu_tx_event, cell_int_event, viterbi_int_event,
     turbo_int_event, clear, completion_event, alt_completion_event} = '0;
    s_axi_wstrb = 4'hf;
    set_periph(0);
    repeat (5) @(posedge clk);
    rst_n <= 1;
    t_regs();
    t_defaults();
    t_codes();
    t_dma();
    t_prio();
    summarize();
  end
endmodule

// ===== interrupt_mux.sv
// per-line source selection for the maskable cpu interrupt lines
`timescale 1ns/1ps
module interrupt_mux (
  // selectors
  select_if.mux selPort,
  // sources and selected levels
  input wire event_routing_pkg::source_t sources,
  output logic [event_routing_pkg::CpuLines-1:event_routing_pkg::FixedLines] selected
);
  import event_routing_pkg::*;
  genvar g;
  generate
    for (g = FixedLines; g < CpuLines; g++) begin : gLine
      assign selected[g] = sources[selPort.sel[g]];
    end
  endgenerate
endmodule

// ===== select_if.sv
// selector fields passed from the register file to the interrupt mux
`timescale 1ns/1ps
interface select_if;
  import event_routing_pkg::*;
  sel_t sel [FixedLines:CpuLines-1];
  modport regs (output sel);
  modport mux (input sel);
endinterface
